// ### logic/asc_pkg.sv
// Shared constants for the converter serial control block
package asc_pkg;

  // Clock and timing
  localparam int CLK_MHZ       = 125;
  localparam int OSC_START_US  = 200;                      // Oscillator start time, microseconds
  localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;   // Cycles of i_clk for oscillator start

  // Widths
  localparam int CODE_W = 24;
  localparam int CHAN_W = 4;

  // Consecutive ones on the data input that reset the interface
  localparam logic [5:0] RESET_ONES = 6'h28;

  // Transfer lengths in bits
  localparam logic [5:0] LEN_BYTE  = 6'h08;
  localparam logic [5:0] LEN_WORD  = 6'h18;
  localparam logic [5:0] LEN_WSTAT = 6'h20;

  // Register select codes
  localparam logic [2:0] RA_COMMS  = 3'h0;   // Write: communications, read: status
  localparam logic [2:0] RA_MODE   = 3'h1;
  localparam logic [2:0] RA_CONFIG = 3'h2;
  localparam logic [2:0] RA_DATA   = 3'h3;
  localparam logic [2:0] RA_ID     = 3'h4;
  localparam logic [2:0] RA_OFFSET = 3'h6;
  localparam logic [2:0] RA_FULL   = 3'h7;

  // Communications byte fields
  localparam int CB_WEN     = 7;
  localparam int CB_READ    = 6;
  localparam int CB_RS_LSB  = 3;
  localparam int CB_CREAD   = 2;
  localparam logic [7:0] CMD_CREAD_EXIT = 8'h58;

  // Mode register fields
  localparam int MF_OPMODE_LSB = 21;
  localparam int MF_APPEND     = 20;
  localparam logic [2:0] OPMODE_CONT   = 3'h0;
  localparam logic [2:0] OPMODE_SINGLE = 3'h1;
  localparam logic [2:0] OPMODE_PDOWN  = 3'h3;

  // Configuration register fields
  localparam int CF_BURN     = 7;
  localparam int CF_REFERENCE_DETECT_ENABLE   = 6;
  localparam int CF_UNIPOLAR = 3;

  // Status byte fields
  localparam int SB_RDY   = 7;
  localparam int SB_ERR   = 6;
  localparam int SB_MISSING_REFERENCE_FLAG = 5;

  // Reset values
  localparam logic [23:0] MODE_RESET   = 24'h000000;
  localparam logic [23:0] CONFIG_RESET = 24'h000000;
  localparam logic [23:0] OFFSET_RESET = 24'h800000;
  localparam logic [23:0] FULL_RESET   = 24'h500000;

  // Identity byte, value is arbitrary
  localparam logic [7:0] ID_DEFAULT = 8'hA5;

endpackage

// ### logic/asc_fifo.sv
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/10ps
module asc_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  logic             i_clk,
  input  logic             i_reset_n,
  // Fill side
  input  logic             i_in_valid,
  output logic             o_in_ready,
  input  logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic             o_out_valid,
  input  logic             i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } asc_fifo_st_t;

  asc_fifo_st_t s;
  asc_fifo_st_t n;
  logic         push;
  logic         pop;

  // Handshakes from occupancy
  assign o_in_ready  = (s.count != FULL);
  assign o_out_valid = (s.count != '0);
  assign o_out_data  = s.mem[s.rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Pointer and count update, pointers wrap at the depth
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr_ptr] = i_in_data;
      n.wr_ptr        = (s.wr_ptr == LAST) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      n.rd_ptr = (s.rd_ptr == LAST) ? '0 : s.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   n.count = s.count + 1'b1;
      2'b01:   n.count = s.count - 1'b1;
      default: n.count = s.count;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule

// ### logic/asc_serial_ctrl.sv
// Serial control, result coding and reference handling of the converter
//
// Behaviour
// - Reference monitoring only while detect enable set
// - Flag sets below low threshold, clears above high
// - Missing reference forces result to all ones
// - Missing reference blocks calibration update, sets error
// - Polarity bit selects unipolar or bipolar range
// - Unipolar output is straight binary code
// - Bipolar output is offset binary code
// - Burnout source and sink switch together
// - After reset expect a communications write first
// - Communications byte selects direction and target register
// - Write data on input, read data on output
// - Ready low on new word, high after read
// - Respond only with chip select; three-wire allowed
// - Data rereadable until update; continuous read once
// - Chip select assertion presents ready; a read load presents most significant bit
// - Forty ones on input reset interface and registers
// - Single conversion powers up, converts, powers down
// - Allow oscillator start time before single conversion
// - Single mode keeps ready high until next result
// - Append status after data; low bits give channel
// - Continuous read command streams each new word that lands while selected
`timescale 1ns/10ps
module asc_serial_ctrl #(
  parameter int         OSC_START_CYCLES = asc_pkg::OSC_START_CYC,
  parameter int         FIFO_DEPTH       = 8,
  parameter logic [7:0] ID_CODE          = asc_pkg::ID_DEFAULT   // Arbitrary value
) (
  // Clock and reset
  input  logic                       i_clk,
  input  logic                       i_reset_n,
  // Serial pins
  input  logic                       i_sclk,
  input  logic                       i_din,
  input  logic                       i_cs_n,
  output logic                       o_dout,
  output logic                       o_dout_oe,
  // Converter results
  input  logic                       i_conv_valid,
  output logic                       o_conv_ready,
  input  logic [asc_pkg::CODE_W-1:0] i_conv_raw,
  input  logic [asc_pkg::CHAN_W-1:0] i_conv_chan,
  output logic                       o_conv_start,
  output logic                       o_modulator_on,
  // Reference comparators
  input  logic                       i_ref_below_low,
  input  logic                       i_ref_above_high,
  // Calibration results
  input  logic                       i_cal_done,
  input  logic                       i_cal_full,
  input  logic [asc_pkg::CODE_W-1:0] i_cal_coef,
  // Analog front end controls and flags
  output logic                       o_burnout_source_en,
  output logic                       o_burnout_sink_en,
  output logic                       o_unipolar,
  output logic                       o_reference_detect_enable,
  output logic                       o_missing_reference_flag,
  output logic                       o_cal_error,
  output logic [asc_pkg::CODE_W-1:0] o_offset_coef,
  output logic [asc_pkg::CODE_W-1:0] o_full_coef
);
  import asc_pkg::*;

  localparam int WCW = $clog2(OSC_START_CYCLES + 1);
  localparam logic [WCW-1:0] WARM_LAST = WCW'(OSC_START_CYCLES - 1);

  typedef enum logic [1:0] {SP_CMD, SP_WR, SP_RD} asc_sp_t;
  typedef enum logic [1:0] {SC_OFF, SC_WARM, SC_CONV} asc_sc_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic din_s1;
    logic din_s2;
    logic cs_s1;
    logic cs_s2;
    logic rlo_s1;
    logic rlo_s2;
    logic rhi_s1;
    logic rhi_s2;
  } asc_sync_t;

  typedef struct packed {
    asc_sync_t          sy;
    asc_sp_t            state;
    logic [5:0]         bit_cnt;
    logic [5:0]         rd_len;
    logic [2:0]         target;
    logic [23:0]        shin;
    logic [31:0]        shout;
    logic               armed;
    logic [5:0]         ones;
    logic [23:0]        mode;
    logic [23:0]        cfg;
    logic [23:0]        offset;
    logic [23:0]        full;
    logic [23:0]        data;
    logic [3:0]         chan;
    logic               rdy_n;
    logic               err;
    logic               missing_reference_flag;
    logic               cread;
    logic               data_rd;
    logic               upd_pend;
    logic [27:0]        upd_word;
    asc_sc_t            sc;
    logic [WCW-1:0]     warm;
    logic               conv_start;
    logic               dout;
  } asc_st_t;

  // Power-on values; also restored by the serial reset
  function automatic asc_st_t rst_val();
    asc_st_t r;
    r          = '0;
    r.sy.cs_s1 = 1'b1;
    r.sy.cs_s2 = 1'b1;
    r.mode     = MODE_RESET;
    r.cfg      = CONFIG_RESET;
    r.offset   = OFFSET_RESET;
    r.full     = FULL_RESET;
    r.rdy_n    = 1'b1;
    r.dout     = 1'b1;
    return r;
  endfunction

  // Result coding from a signed fraction of full scale
  function automatic logic [23:0] code_word(input logic [23:0] raw, input logic uni,
                                            input logic nref);
    if (nref) begin
      return '1;
    end else if (!uni) begin
      return {~raw[23], raw[22:0]};
    end else if (raw[23]) begin
      return '0;
    end else if (&raw[22:0]) begin
      return '1;
    end else begin
      return {raw[22:0], 1'b0};
    end
  endfunction

  // Status byte: ready, error, missing reference, channel
  function automatic logic [7:0] status_byte(input asc_st_t t);
    status_byte          = {4'h0, t.chan};
    status_byte[SB_RDY]   = t.rdy_n;
    status_byte[SB_ERR]   = t.err;
    status_byte[SB_MISSING_REFERENCE_FLAG] = t.missing_reference_flag;
  endfunction

  asc_st_t     s;
  asc_st_t     n;
  asc_sync_t   sy_next;
  logic        cs_on;
  logic        rise;
  logic        fall;
  logic [7:0]  cmd_byte;
  logic [23:0] wr_word;
  logic        fifo_valid;
  logic        pop_ok;
  logic [27:0] fifo_word;
  logic [27:0] push_word;
  logic        push;

  // Edge detection on the second synchroniser stage only
  assign cs_on     = ~s.sy.cs_s2;
  assign rise      = cs_on & s.sy.sclk_s2 & ~s.sy.sclk_d;
  assign fall      = cs_on & ~s.sy.sclk_s2 & s.sy.sclk_d;
  assign cmd_byte  = {s.shin[6:0], s.sy.din_s2};
  assign wr_word   = {s.shin[22:0], s.sy.din_s2};
  assign push_word = {i_conv_chan,
                      code_word(i_conv_raw, s.cfg[CF_UNIPOLAR], s.missing_reference_flag)};
  assign push      = i_conv_valid & o_conv_ready;
  // Hold new words back while a data read is in flight, except in continuous read
  assign pop_ok    = fifo_valid & ~s.upd_pend &
                     ~((s.state == SP_RD) & s.data_rd & ~s.cread);

  // Result buffer between converter and data register
  asc_fifo #(
    .WIDTH (28),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_conv_valid),
    .o_in_ready  (o_conv_ready),
    .i_in_data   (push_word),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop_ok),
    .o_out_data  (fifo_word)
  );

  // Next-state logic
  always_comb begin
    n            = s;
    n.conv_start = 1'b0;
    // Two-stage synchronisers for pins and comparators
    n.sy.sclk_s1 = i_sclk;
    n.sy.sclk_s2 = s.sy.sclk_s1;
    n.sy.sclk_d  = s.sy.sclk_s2;
    n.sy.din_s1  = i_din;
    n.sy.din_s2  = s.sy.din_s1;
    n.sy.cs_s1   = i_cs_n;
    n.sy.cs_s2   = s.sy.cs_s1;
    n.sy.rlo_s1  = i_ref_below_low;
    n.sy.rlo_s2  = s.sy.rlo_s1;
    n.sy.rhi_s1  = i_ref_above_high;
    n.sy.rhi_s2  = s.sy.rhi_s1;
    sy_next      = n.sy;

    // Reference flag with hysteresis, idle while detect is off
    if (!s.cfg[CF_REFERENCE_DETECT_ENABLE]) begin
      n.missing_reference_flag = 1'b0;
    end else if (s.sy.rlo_s2) begin
      n.missing_reference_flag = 1'b1;
    end else if (s.sy.rhi_s2) begin
      n.missing_reference_flag = 1'b0;
    end

    // Calibration result: blocked and flagged without a reference
    if (i_cal_done) begin
      if (s.missing_reference_flag) begin
        n.err = 1'b1;
      end else begin
        n.err = 1'b0;
        if (i_cal_full) begin
          n.full = i_cal_coef;
        end else begin
          n.offset = i_cal_coef;
        end
      end
    end

    // Oscillator warm-up ahead of a single conversion
    if (s.sc == SC_WARM) begin
      n.warm = s.warm + 1'b1;
      if (s.warm == WARM_LAST) begin
        n.sc         = SC_CONV;
        n.conv_start = 1'b1;
      end
    end

    // Serial engine
    if (!cs_on) begin
      n.state   = SP_CMD;
      n.bit_cnt = '0;
      n.armed   = 1'b0;
      n.data_rd = 1'b0;
    end else begin
      if (fall && s.state == SP_RD) begin
        if (s.armed) begin
          n.shout = {s.shout[30:0], 1'b0};
        end
        n.armed = 1'b1;
      end
      if (rise) begin
        n.ones    = s.sy.din_s2 ? s.ones + 1'b1 : '0;
        n.shin    = wr_word;
        n.bit_cnt = s.bit_cnt + 1'b1;
        case (s.state)
          SP_CMD: begin
            if (s.bit_cnt == LEN_BYTE - 6'h01) begin
              n.bit_cnt = '0;
              n.target  = cmd_byte[CB_RS_LSB +: 3];
              if (s.cread) begin
                if (cmd_byte == CMD_CREAD_EXIT) begin
                  n.cread = 1'b0;
                end
              end else if (cmd_byte[CB_WEN]) begin
                n.state = SP_CMD;
              end else if (!cmd_byte[CB_READ]) begin
                n.state = SP_WR;
              end else if (cmd_byte[CB_RS_LSB +: 3] == RA_DATA && cmd_byte[CB_CREAD]) begin
                n.cread = 1'b1;
              end else begin
                n.state = SP_RD;
                n.armed = 1'b0;
                n.rd_len = LEN_WORD;
                n.data_rd = 1'b0;
                case (cmd_byte[CB_RS_LSB +: 3])
                  RA_COMMS:  begin
                    n.shout  = {status_byte(s), 24'h000000};
                    n.rd_len = LEN_BYTE;
                  end
                  RA_MODE:   n.shout = {s.mode, 8'h00};
                  RA_CONFIG: n.shout = {s.cfg, 8'h00};
                  RA_DATA:   begin
                    n.data_rd = 1'b1;
                    n.shout   = {s.data, status_byte(s)};
                    n.rd_len  = s.mode[MF_APPEND] ? LEN_WSTAT : LEN_WORD;
                  end
                  RA_ID:     begin
                    n.shout  = {ID_CODE, 24'h000000};
                    n.rd_len = LEN_BYTE;
                  end
                  RA_OFFSET: n.shout = {s.offset, 8'h00};
                  RA_FULL:   n.shout = {s.full, 8'h00};
                  default:   begin
                    n.shout  = '0;
                    n.rd_len = LEN_BYTE;
                  end
                endcase
              end
            end
          end
          SP_WR: begin
            if (s.bit_cnt == ((s.target == RA_COMMS || s.target == RA_ID) ?
                              LEN_BYTE : LEN_WORD) - 6'h01) begin
              n.state   = SP_CMD;
              n.bit_cnt = '0;
              case (s.target)
                RA_MODE: begin
                  n.mode = wr_word;
                  if (wr_word[MF_OPMODE_LSB +: 3] == OPMODE_SINGLE) begin
                    n.sc   = SC_WARM;
                    n.warm = '0;
                  end else begin
                    n.sc = SC_OFF;
                  end
                end
                RA_CONFIG: n.cfg    = wr_word;
                RA_OFFSET: n.offset = wr_word;
                RA_FULL:   n.full   = wr_word;
                default:   n.state  = SP_CMD;
              endcase
            end
          end
          SP_RD: begin
            if (s.bit_cnt == s.rd_len - 6'h01) begin
              n.state   = SP_CMD;
              n.bit_cnt = '0;
              if (s.data_rd) begin
                n.rdy_n   = 1'b1;
                n.data_rd = 1'b0;
              end
            end
          end
          default: n.state = SP_CMD;
        endcase
      end
    end

    // Data register update: ready rises one cycle before the new word lands
    if (pop_ok) begin
      n.upd_pend = 1'b1;
      n.upd_word = fifo_word;
      n.rdy_n    = 1'b1;
    end
    if (s.upd_pend) begin
      n.upd_pend = 1'b0;
      n.data     = s.upd_word[23:0];
      n.chan     = s.upd_word[27:24];
      n.rdy_n    = 1'b0;
      if (s.sc == SC_CONV) begin
        n.sc                          = SC_OFF;
        n.mode[MF_OPMODE_LSB +: 3]    = OPMODE_PDOWN;
      end
      // Stream only while selected, so a deselected engine stays in command wait
      if (s.cread && cs_on) begin
        n.state   = SP_RD;
        n.bit_cnt = '0;
        n.armed   = 1'b0;
        n.data_rd = 1'b1;
        n.shout   = {s.upd_word[23:0], status_byte(n)};
        n.rd_len  = s.mode[MF_APPEND] ? LEN_WSTAT : LEN_WORD;
      end
    end

    // Forty ones on the data input: back to power-on state
    if (rise && s.sy.din_s2 && s.ones == RESET_ONES - 6'h01) begin
      n    = rst_val();
      n.sy = sy_next;
    end

    // Output pin: shifted data during a read, otherwise ready
    n.dout = (n.state == SP_RD) ? n.shout[31] : n.rdy_n;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= rst_val();
    end else begin
      s <= n;
    end
  end

  // Output drive
  assign o_dout                    = s.dout;
  assign o_dout_oe                 = cs_on;
  assign o_conv_start              = s.conv_start;
  assign o_modulator_on            = (s.mode[MF_OPMODE_LSB +: 3] == OPMODE_CONT) ||
                                     (s.sc != SC_OFF);
  assign o_burnout_source_en       = s.cfg[CF_BURN];
  assign o_burnout_sink_en         = s.cfg[CF_BURN];
  assign o_unipolar                = s.cfg[CF_UNIPOLAR];
  assign o_reference_detect_enable = s.cfg[CF_REFERENCE_DETECT_ENABLE];
  assign o_missing_reference_flag  = s.missing_reference_flag;
  assign o_cal_error               = s.err;
  assign o_offset_coef             = s.offset;
  assign o_full_coef               = s.full;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence upd_begin_s;
    s.upd_pend && s.rdy_n;
  endsequence
  sequence upd_land_s;
    !s.rdy_n && (s.data == $past(s.upd_word[23:0]));
  endsequence

  refmon_off_a: assert property (!s.cfg[CF_REFERENCE_DETECT_ENABLE] |=> !s.missing_reference_flag)
    else $error("flag set while detect disabled");
  refmon_set_a: assert property (s.cfg[CF_REFERENCE_DETECT_ENABLE] && s.sy.rlo_s2 |=> s.missing_reference_flag)
    else $error("flag not set below low threshold");
  missing_reference_flag_ones_a: assert property (push && s.missing_reference_flag |-> push_word[23:0] == 24'hFFFFFF)
    else $error("result not all ones without reference");
  cal_block_a: assert property (i_cal_done && s.missing_reference_flag
                                |=> s.err && $stable(s.offset) && $stable(s.full))
    else $error("calibration updated without reference");
  bip_code_a: assert property (push && !s.cfg[CF_UNIPOLAR] && !s.missing_reference_flag
                               |-> push_word[23:0] == {~i_conv_raw[23], i_conv_raw[22:0]})
    else $error("bipolar code wrong");
  uni_code_a: assert property (push && s.cfg[CF_UNIPOLAR] && !s.missing_reference_flag && i_conv_raw[23]
                               |-> push_word[23:0] == 24'h000000)
    else $error("unipolar negative code not zero");
  burn_pair_a: assert property (o_burnout_source_en == o_burnout_sink_en)
    else $error("burnout currents not paired");
  rdy_update_a: assert property (upd_begin_s |=> upd_land_s)
    else $error("ready or data wrong on update");
  serial_rst_a: assert property (rise && s.sy.din_s2 && s.ones == 6'h27
                                 |=> s.state == SP_CMD && s.mode == MODE_RESET && !s.cread)
    else $error("serial reset not applied");
  warm_start_a: assert property (s.conv_start |-> s.sc == SC_CONV && $past(s.sc) == SC_WARM)
    else $error("conversion started without warm-up");
  cs_idle_a: assert property (s.sy.cs_s2 |=> s.state == SP_CMD && s.bit_cnt == 6'h00)
    else $error("engine active without chip select");

endmodule

// ### test/asc_host.sv
// Host model that frames and clocks the serial link of the converter
`timescale 1ns/10ps
module asc_host (
  // Serial pins
  input  logic i_dout,
  output logic o_sclk,
  output logic o_din,
  output logic o_cs_n
);
  logic [31:0] rx;
  // Idle levels: clock high, not selected
  initial begin
    o_sclk = 1'b1;
    o_din  = 1'b0;
    o_cs_n = 1'b1;
    rx     = 32'h0;
  end
  // One framed transfer, shifted out on fall and sampled before the rise
  task automatic xfer(input logic [63:0] v, input int n);
    o_cs_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din  = v[i];
      #62.5;
      rx     = {rx[30:0], i_dout};
      o_sclk = 1'b1;
      #62.5;
    end
    #100;
    o_cs_n = 1'b1;
    o_din  = ~o_din; // Released line keeps no stale level
    #100; // Deselected gap before any next frame
  endtask
endmodule

// ### test/asc_serial_ctrl_bench.sv
// Self-checking bench for the converter serial control block
`timescale 1ns/10ps
module asc_serial_ctrl_bench;
  import asc_pkg::*;
  logic              i_clk, i_reset_n, sclk, din, cs_n, dout, valid, ready;
  logic              below, above, cal_done, cal_full, bsrc, bsnk, unip, rdet, missing_reference_flag, cerr;
  logic              mod_on;
  logic [CODE_W-1:0] raw, coef, offc, fullc, v, e;
  logic [CHAN_W-1:0] chan;
  logic [CODE_W-1:0] exp_q[$];
  event              rd_evt;
  int                err_total, comparisons, cyc, seed;

  asc_host asc_host_i (.i_dout(dout), .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));
  asc_serial_ctrl #(.OSC_START_CYCLES(20)) asc_serial_ctrl_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n),
    .o_dout(dout), .o_dout_oe(), .i_conv_valid(valid), .o_conv_ready(ready),
    .i_conv_raw(raw), .i_conv_chan(chan), .o_conv_start(), .o_modulator_on(mod_on),
    .i_ref_below_low(below), .i_ref_above_high(above), .i_cal_done(cal_done),
    .i_cal_full(cal_full), .i_cal_coef(coef), .o_burnout_source_en(bsrc),
    .o_burnout_sink_en(bsnk), .o_unipolar(unip), .o_reference_detect_enable(rdet),
    .o_missing_reference_flag(missing_reference_flag), .o_cal_error(cerr), .o_offset_coef(offc),
    .o_full_coef(fullc));

  // Clock of 8 ns
  always #4 i_clk = ~i_clk;

  task automatic cmp(input string nm, input logic [CODE_W-1:0] ex, input logic [CODE_W-1:0] g);
    comparisons++;
    if (g !== ex) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wr(input logic [7:0] cb, input logic [23:0] d);
    asc_host_i.xfer({32'h0, cb, d}, 32);
  endtask
  task automatic rd(input logic [7:0] cb, input logic [23:0] ex);
    exp_q.push_back(ex);
    asc_host_i.xfer({32'h0, cb, 24'h0}, 32);
    ->rd_evt;
  endtask
  // Watcher takes the oldest note for each finished read
  always @(rd_evt) cmp("read word", exp_q.pop_front(), asc_host_i.rx[23:0]);
  task automatic push(input logic [23:0] d);
    @(posedge i_clk) #1;
    raw   = d;
    chan  = d[3:0];
    valid = 1'b1;
    do @(posedge i_clk); while (ready !== 1'b1);
    #1 valid = 1'b0;
    repeat (10) @(posedge i_clk);
  endtask
  task automatic cal(input logic [23:0] c);
    @(posedge i_clk) #1;
    cal_done = 1'b1;
    cal_full = 1'b1;
    coef     = c;
    @(posedge i_clk) #1;
    cal_done = 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 50000) begin
      err_total++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    {i_clk, i_reset_n, valid, raw, chan, below, cal_done, cal_full, coef} = '0;
    above = 1'b1;
    seed  = 6;
    repeat (20) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    repeat (5) @(posedge i_clk);
    cmp("offset reset", 24'h800000, offc);
    cmp("full reset", 24'h500000, fullc);
    wr(8'h10, 24'h000088);
    cmp("burn source", 1, bsrc);
    cmp("burn sink", 1, bsnk);
    cmp("unipolar", 1, unip);
    rd(8'h50, 24'h000088);
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, k ? 24'h0 : 24'h8);
      v = $random(seed);
      if (k == 0) v[23:22] = 2'h0;
      e = k ? {~v[23], v[22:0]} : {v[22:0], 1'b0};
      push(v);
      cmp("ready low", 0, dout);
      rd(8'h58, e);
      cmp("ready high", 1, dout);
      rd(8'h58, e);
    end
    $display("test coding done");
    wr(8'h10, 24'h000040);
    @(posedge i_clk) #1;
    below = 1'b1;
    above = 1'b0;
    repeat (6) @(posedge i_clk);
    cmp("no reference", 1, missing_reference_flag);
    push(24'h123456);
    rd(8'h58, 24'hFFFFFF);
    cal(24'h654321);
    cmp("cal error", 1, cerr);
    cmp("full kept", 24'h500000, fullc);
    @(posedge i_clk) #1;
    below = 1'b0;
    above = 1'b1;
    repeat (6) @(posedge i_clk);
    cmp("reference back", 0, missing_reference_flag);
    cal(24'h654321);
    cmp("full loaded", 24'h654321, fullc);
    $display("test reference done");
    cmp("modulator on", 1, mod_on);
    wr(8'h08, 24'h200000);
    repeat (30) @(posedge i_clk);
    push(24'h000100);
    rd(8'h48, 24'h600000);
    cmp("modulator off", 0, mod_on);
    $display("test single conversion done");
    asc_host_i.xfer({64{1'b1}}, 48);
    #200000;
    cmp("detect cleared", 0, rdet);
    cmp("full restored", 24'h500000, fullc);
    rd(8'h50, 24'h000000);
    $display("test serial reset done");
    wrap_up();
  end
endmodule
